/* File: verilog/rtcsa_pkg.sv */
package rtcsa_pkg;
	localparam logic [6:0] RTCSA_DEV_ADDR      = 7'h68;
	localparam logic [7:0] RTCSA_MAP_LAST      = 8'h9F;
	localparam logic [7:0] RTCSA_CLOCK_LAST    = 8'h07;
	localparam logic [7:0] RTCSA_PTR_RESET     = 8'h00;
	localparam logic [7:0] RTCSA_SUBSECOND     = 8'h00;
	localparam logic [7:0] RTCSA_SECONDS       = 8'h01;
	localparam logic [7:0] RTCSA_MINUTES       = 8'h02;
	localparam logic [7:0] RTCSA_CENT_HOURS    = 8'h03;
	localparam logic [7:0] RTCSA_WEEKDAY       = 8'h04;
	localparam logic [7:0] RTCSA_DAY_OF_MONTH  = 8'h05;
	localparam logic [7:0] RTCSA_MONTH         = 8'h06;
	localparam logic [7:0] RTCSA_YEAR          = 8'h07;
	localparam logic [7:0] RTCSA_GEN_CONTROL   = 8'h08;
	localparam logic [7:0] RTCSA_TIMER_SETUP   = 8'h09;
	localparam logic [7:0] RTCSA_ALARM_FIRST   = 8'h0A;
	localparam logic [7:0] RTCSA_ALARM_LAST    = 8'h0E;
	localparam logic [7:0] RTCSA_EVENT_FLAGS   = 8'h0F;
	localparam logic [7:0] RTCSA_RSVD_A_FIRST  = 8'h10;
	localparam logic [7:0] RTCSA_SQW_TAMPER    = 8'h13;
	localparam logic [7:0] RTCSA_INTRUSION_1   = 8'h14;
	localparam logic [7:0] RTCSA_INTRUSION_2   = 8'h15;
	localparam logic [7:0] RTCSA_UID_FIRST     = 8'h16;
	localparam logic [7:0] RTCSA_UID_LAST      = 8'h1D;
	localparam logic [7:0] RTCSA_RSVD_B_FIRST  = 8'h1E;
	localparam logic [7:0] RTCSA_RSVD_B_LAST   = 8'h1F;
	localparam logic [7:0] RTCSA_RAM_FIRST     = 8'h20;
	localparam logic [7:0] RTCSA_MEM_RESET     = 8'h00;
	// arbitrary unique id seed, not a real serial number
	localparam logic [7:0] RTCSA_UID_SEED      = 8'h5A;
	// recovery delay after supply returns
	localparam int         RTCSA_REC_US        = 40;
	localparam int         RTCSA_CLK_MHZ       = 125;
	localparam int         RTCSA_REC_CYC       = RTCSA_REC_US * RTCSA_CLK_MHZ;
	// master: system cycles per quarter bit phase (8 -> 64 ns)
	localparam int         RTCSA_HALF_CYC      = 8;
	// controller register byte offsets on APB
	localparam logic [7:0] RTCSA_R_CMD         = 8'h00;
	localparam logic [7:0] RTCSA_R_STATUS      = 8'h04;
	localparam logic [7:0] RTCSA_R_RXDATA      = 8'h08;
	localparam logic [31:0] RTCSA_ERR_WORD     = 32'h0000_0000;
	// command word and status register bit positions
	localparam int         RTCSA_CMD_START     = 8;
	localparam int         RTCSA_CMD_STOP      = 9;
	localparam int         RTCSA_CMD_READ      = 10;
	localparam int         RTCSA_CMD_NACK      = 11;
	localparam int         RTCSA_ST_BUSY       = 0;
	localparam int         RTCSA_ST_NACK       = 1;
endpackage : rtcsa_pkg

/* File: verilog/rtcsa_link_if.sv */
`timescale 1ns/10ps
interface rtcsa_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	// open drain wire level from the enables, pulled up when idle
	wire  scl = !(scl_oe && !scl_o);
	wire  sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport master (
		output scl_o,
		output scl_oe,
		output sda_m_o,
		output sda_m_oe,
		input  scl,
		input  sda
	);
	modport device (
		output sda_s_o,
		output sda_s_oe,
		input  scl,
		input  sda
	);
endinterface : rtcsa_link_if

/* File: verilog/rtcsa_sync.sv */
`timescale 1ns/10ps
module rtcsa_sync (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q   <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // rtcsa_sync

/* File: verilog/rtcsa_device.sv */
`timescale 1ns/10ps
module rtcsa_device (
	input  wire logic  clk,
	input  wire logic  reset,
	rtcsa_link_if.device link,
	input  wire logic  supply_ok,
	output logic       clock_freeze,
	output logic       access_enabled,
	output logic [7:0] word_pointer_value
);
	import rtcsa_pkg::*;

	typedef enum logic [2:0] {
		RTCSA_S_IDLE  = 3'b000,
		RTCSA_S_ADDR  = 3'b001,
		RTCSA_S_WORD  = 3'b010,
		RTCSA_S_WDATA = 3'b011,
		RTCSA_S_RDATA = 3'b100,
		RTCSA_S_RACK  = 3'b101
	} rtcsa_state_type;

	logic [7:0]      mem_q [0:159];
	rtcsa_state_type state_q;
	logic            scl_s, sda_s, scl_p_q, sda_p_q, sup_s;
	logic [3:0]      bit_q;
	logic [7:0]      shift_q;
	logic [7:0]      ptr_q;
	logic            ack_phase_q;
	logic            drive_low_q;
	logic [31:0]     rec_q;
	logic            start_ev, stop_ev, scl_rise, scl_fall;

	rtcsa_sync u_scl (.clk(clk), .reset(reset), .async_in(link.scl),
		.sync_out(scl_s));
	rtcsa_sync u_sda (.clk(clk), .reset(reset), .async_in(link.sda),
		.sync_out(sda_s));
	rtcsa_sync u_sup (.clk(clk), .reset(reset), .async_in(supply_ok),
		.sync_out(sup_s));

	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		next_ptr = (p == RTCSA_MAP_LAST) ? RTCSA_PTR_RESET : p + 8'h01;
	endfunction

	function automatic logic writable(input logic [7:0] p);
		writable = !((p >= RTCSA_UID_FIRST && p <= RTCSA_UID_LAST) ||
			(p >= RTCSA_RSVD_A_FIRST && p < RTCSA_SQW_TAMPER) ||
			(p >= RTCSA_RSVD_B_FIRST && p <= RTCSA_RSVD_B_LAST));
	endfunction

	assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// recovery delay counted after supply returns
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rec_q <= 32'h0000_0000;
		end else if (!sup_s) begin
			rec_q <= 32'h0000_0000;
		end else if (rec_q < RTCSA_REC_CYC) begin
			rec_q <= rec_q + 32'h0000_0001;
		end
	end
	assign access_enabled = sup_s && (rec_q >= RTCSA_REC_CYC);

	// link engine: bits sampled on scl rise, sda changed on scl fall
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q     <= RTCSA_S_IDLE;
			bit_q       <= 4'h0;
			shift_q     <= 8'h00;
			ptr_q       <= RTCSA_PTR_RESET;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
		end else if (!access_enabled) begin
			state_q     <= RTCSA_S_IDLE;
			ptr_q       <= RTCSA_PTR_RESET;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
			bit_q       <= 4'h0;
		end else if (start_ev) begin
			state_q     <= RTCSA_S_ADDR;
			bit_q       <= 4'h0;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
		end else if (stop_ev) begin
			state_q     <= RTCSA_S_IDLE;
			ack_phase_q <= 1'b0;
			drive_low_q <= 1'b0;
		end else if (scl_rise && !ack_phase_q) begin
			case (state_q)
				RTCSA_S_ADDR, RTCSA_S_WORD, RTCSA_S_WDATA: begin
					shift_q <= {shift_q[6:0], sda_s};
					bit_q   <= bit_q + 4'h1;
				end
				RTCSA_S_RDATA: begin
					bit_q <= bit_q + 4'h1;
				end
				default: begin
					bit_q <= bit_q;
				end
			endcase
		end else if (scl_rise && ack_phase_q && state_q == RTCSA_S_RACK) begin
			// master ack sampled; nack releases until the next start
			if (!sda_s) begin
				ptr_q   <= next_ptr(ptr_q);
				state_q <= RTCSA_S_RDATA;
			end else begin
				state_q <= RTCSA_S_IDLE;
			end
		end else if (scl_fall) begin
			if (ack_phase_q) begin
				ack_phase_q <= 1'b0;
				drive_low_q <= 1'b0;
				bit_q       <= 4'h0;
				if (state_q == RTCSA_S_RDATA) begin
					drive_low_q <= !mem_q[ptr_q][7];
				end
			end else if (bit_q == 4'h8) begin
				ack_phase_q <= 1'b1;
				case (state_q)
					RTCSA_S_ADDR: begin
						if (shift_q[7:1] == RTCSA_DEV_ADDR) begin
							drive_low_q <= 1'b1;
							if (shift_q[0]) begin
								state_q <= RTCSA_S_RDATA;
							end else begin
								state_q <= RTCSA_S_WORD;
							end
						end else begin
							state_q     <= RTCSA_S_IDLE;
							ack_phase_q <= 1'b0;
						end
					end
					RTCSA_S_WORD: begin
						ptr_q       <= (shift_q > RTCSA_MAP_LAST) ?
							RTCSA_PTR_RESET : shift_q;
						drive_low_q <= 1'b1;
						state_q     <= RTCSA_S_WDATA;
					end
					RTCSA_S_WDATA: begin
						ptr_q       <= next_ptr(ptr_q);
						drive_low_q <= 1'b1;
					end
					RTCSA_S_RDATA: begin
						drive_low_q <= 1'b0;
						state_q     <= RTCSA_S_RACK;
					end
					default: begin
						ack_phase_q <= 1'b0;
					end
				endcase
			end else if (state_q == RTCSA_S_RDATA) begin
				// next data bit set up while scl low
				drive_low_q <= !mem_q[ptr_q][3'(7 - bit_q)];
			end
		end
	end

	// ack held low until scl falls after its high period
	assign link.sda_s_oe = drive_low_q;
	assign link.sda_s_o  = 1'b0;

	// byte store at ack boundary of a write data byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 160; i++) begin
				if (i >= RTCSA_UID_FIRST && i <= RTCSA_UID_LAST) begin
					mem_q[i] <= RTCSA_UID_SEED ^ 8'(i);
				end else begin
					mem_q[i] <= RTCSA_MEM_RESET;
				end
			end
		end else if (access_enabled && scl_fall && !ack_phase_q &&
			bit_q == 4'h8 && state_q == RTCSA_S_WDATA &&
			writable(ptr_q)) begin
			mem_q[ptr_q] <= shift_q;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clock_freeze <= 1'b0;
		end else begin
			clock_freeze <= (state_q != RTCSA_S_IDLE) &&
				(ptr_q <= RTCSA_CLOCK_LAST);
		end
	end

	assign word_pointer_value = ptr_q;
endmodule // rtcsa_device

/* File: verilog/rtcsa_master.sv */
`timescale 1ns/10ps
// apb controlled master: one command word per byte
module rtcsa_master (
	input  wire logic   clk,
	input  wire logic   reset,
	rtcsa_link_if.master link,
	input  wire logic   psel,
	input  wire logic   penable,
	input  wire logic   pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr
);
	import rtcsa_pkg::*;

	typedef enum logic [2:0] {
		RTCSA_M_IDLE  = 3'b000,
		RTCSA_M_START = 3'b001,
		RTCSA_M_BIT   = 3'b010,
		RTCSA_M_STOP  = 3'b011,
		RTCSA_M_DONE  = 3'b100
	} rtcsa_mstate_type;

	rtcsa_mstate_type st_q;
	logic [11:0] cmd_q;
	logic [7:0]  rx_q;
	logic        nack_q, scl_q, sda_q;
	logic [3:0]  bit_q;
	logic [1:0]  ph_q;
	logic [7:0]  div_q;
	logic        tick, sda_s, wr_cmd;

	rtcsa_sync u_sda (.clk(clk), .reset(reset), .async_in(link.sda),
		.sync_out(sda_s));

	assign tick    = (div_q == 8'(RTCSA_HALF_CYC - 1));
	assign wr_cmd  = psel && penable && pwrite && paddr == RTCSA_R_CMD &&
		st_q == RTCSA_M_IDLE;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(paddr == RTCSA_R_CMD ||
		paddr == RTCSA_R_STATUS || paddr == RTCSA_R_RXDATA);

	// read word captured in setup, so the access needs no wait state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= RTCSA_ERR_WORD;
		end else if (psel && !penable) begin
			case (paddr)
				RTCSA_R_STATUS: begin
					prdata <= {30'h0, nack_q, st_q != RTCSA_M_IDLE};
				end
				RTCSA_R_RXDATA: begin
					prdata <= {24'h0, rx_q};
				end
				default: begin
					prdata <= RTCSA_ERR_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_q <= 8'h00;
		end else if (tick || st_q == RTCSA_M_IDLE) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// each bit: ph0 set sda (scl low), ph1 scl high, ph2 sample, ph3 scl low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q   <= RTCSA_M_IDLE;
			cmd_q  <= 12'h000;
			rx_q   <= 8'h00;
			nack_q <= 1'b0;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			bit_q  <= 4'h0;
			ph_q   <= 2'h0;
		end else if (wr_cmd) begin
			cmd_q <= pwdata[11:0];
			bit_q <= 4'h0;
			ph_q  <= 2'h0;
			st_q  <= pwdata[RTCSA_CMD_START] ? RTCSA_M_START : RTCSA_M_BIT;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
			case (st_q)
				RTCSA_M_START: begin
					// release then sda low while scl high
					case (ph_q)
						2'h0: sda_q <= 1'b1;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_q <= 1'b0;
						default: begin
							scl_q <= 1'b0;
							st_q  <= RTCSA_M_BIT;
						end
					endcase
				end
				RTCSA_M_BIT: begin
					case (ph_q)
						2'h0: begin
							if (bit_q < 4'h8) begin
								sda_q <= cmd_q[RTCSA_CMD_READ] ? 1'b1 :
									cmd_q[3'(7 - bit_q)];
							end else begin
								sda_q <= cmd_q[RTCSA_CMD_READ] ?
									cmd_q[RTCSA_CMD_NACK] : 1'b1;
							end
						end
						2'h1: scl_q <= 1'b1;
						2'h2: begin
							if (bit_q < 4'h8) begin
								rx_q <= {rx_q[6:0], sda_s};
							end else if (!cmd_q[RTCSA_CMD_READ]) begin
								nack_q <= sda_s;
							end
						end
						default: begin
							scl_q <= 1'b0;
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h8) begin
								st_q <= cmd_q[RTCSA_CMD_STOP] ?
									RTCSA_M_STOP : RTCSA_M_DONE;
							end
						end
					endcase
				end
				RTCSA_M_STOP: begin
					case (ph_q)
						2'h0: sda_q <= 1'b0;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_q <= 1'b1;
						default: st_q <= RTCSA_M_DONE;
					endcase
				end
				default: begin
					st_q <= RTCSA_M_IDLE;
				end
			endcase
		end
	end

	assign link.scl_o    = 1'b0;
	assign link.scl_oe   = !scl_q;
	assign link.sda_m_o  = 1'b0;
	assign link.sda_m_oe = !sda_q;
endmodule // rtcsa_master

/* File: testbench/rtcsa_monitor.sv */
`timescale 1ns/10ps
module rtcsa_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe,
	input wire logic access_enabled
);
	import rtcsa_pkg::*;
	logic       scl_p_q, sda_p_q, first_q, sel_q, rd_q, quiet_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	wire        rise_w  = scl && !scl_p_q;
	wire        start_w = scl && scl_p_q && sda_p_q && !sda;
	wire        stop_w  = scl && scl_p_q && !sda_p_q && sda;
	wire        ninth_w = rise_w && bit_q == 4'h8;
	wire        match_w = sh_q[7:1] == RTCSA_DEV_ADDR;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end
	// pulses 0..7 carry bits, pulse 8 is the acknowledge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_q <= 4'h0;
			sh_q  <= 8'h00;
		end else if (start_w || ninth_w) begin
			bit_q <= 4'h0;
		end else if (rise_w) begin
			bit_q <= bit_q + 4'h1;
			sh_q  <= {sh_q[6:0], sda};
		end
	end
	// supply loss drops selection, as the device forgets it too
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			first_q <= 1'b0;
			sel_q   <= 1'b0;
			rd_q    <= 1'b0;
		end else if (start_w || stop_w || !access_enabled) begin
			first_q <= start_w;
			sel_q   <= 1'b0;
		end else if (ninth_w && first_q) begin
			first_q <= 1'b0;
			sel_q   <= match_w;
			rd_q    <= sh_q[0];
		end
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			quiet_q <= 1'b0;
		else if (start_w || stop_w)
			quiet_q <= 1'b0;
		else if (ninth_w && !first_q && sel_q && rd_q && sda)
			quiet_q <= 1'b1;
	end
	sequence ack_s;
		ninth_w && !first_q && sel_q;
	endsequence
	sequence stop_s;
		stop_w;
	endsequence
	dev_hold_a:
	assert property (disable iff (reset || !access_enabled)
		scl && scl_p_q |-> $stable(sda_s_oe))
		else $error("device data moved in clock high");
	addr_quiet_a:
	assert property (first_q && bit_q != 4'h8 |-> !sda_s_oe)
		else $error("device drove during address byte");
	no_match_a:
	assert property (ninth_w && first_q && !match_w |-> !sda_s_oe)
		else $error("foreign address acknowledged");
	addr_ack_a:
	assert property (ninth_w && first_q && match_w && access_enabled
		|-> sda_s_oe)
		else $error("own address not acknowledged");
	data_ack_a:
	assert property (ack_s ##0 (!rd_q && access_enabled) |-> sda_s_oe)
		else $error("written byte not acknowledged");
	read_release_a:
	assert property (ack_s ##0 rd_q |-> !sda_s_oe)
		else $error("device held data in master ack");
	nack_quiet_a:
	assert property (quiet_q |-> !sda_s_oe)
		else $error("device drove after master nack");
	stop_release_a:
	assert property (stop_s |=> !sda_s_oe [*8])
		else $error("device drove after stop");
endmodule // rtcsa_monitor

/* File: testbench/rtc_serial_slave_access_tb.sv */
`timescale 1ns/10ps
module rtc_serial_slave_access_tb;
	import rtcsa_pkg::*;
	logic        clk, reset, supply_ok, psel, penable, pwrite, chk, rerr;
	logic        pready, pslverr, clock_freeze, access_enabled;
	logic [7:0]  paddr, word_pointer_value;
	logic [31:0] pwdata, prdata, rdat, rnd_q;
	logic [63:0] exp_q [$];
	logic [63:0] nx;
	logic [7:0]  mem [0:159];
	int          mismatches, compares;
	rtcsa_link_if link ();
	rtcsa_device u_rtcsa_device (.clk, .reset, .link, .supply_ok,
		.clock_freeze, .access_enabled, .word_pointer_value);
	rtcsa_master u_rtcsa_master (.clk, .reset, .link, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	rtcsa_monitor u_rtcsa_monitor (.clk, .reset, .scl(link.scl),
		.sda(link.sda), .sda_s_oe(link.sda_s_oe), .access_enabled);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] rnd_byte();
		rnd_q ^= rnd_q << 13;
		rnd_q ^= rnd_q >> 17;
		rnd_q ^= rnd_q << 5;
		return rnd_q[7:0];
	endfunction
	function automatic logic fixed(logic [7:0] a);
		return (a >= RTCSA_RSVD_A_FIRST && a < RTCSA_SQW_TAMPER) ||
			(a >= RTCSA_UID_FIRST && a <= RTCSA_RSVD_B_LAST);
	endfunction
	function automatic logic [7:0] model(logic [7:0] a);
		if (!fixed(a))
			return mem[a];
		return (a <= RTCSA_UID_LAST && a >= RTCSA_UID_FIRST) ?
			RTCSA_UID_SEED ^ a : 8'h00;
	endfunction
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic c);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		chk <= c;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// results are compared when they appear, against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && chk && exp_q.size() > 0) begin
			nx = exp_q.pop_front();
			check("prdata", prdata & nx[63:32], nx[31:0]);
		end
	end
	task automatic expect_rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		exp_q.push_back({m, e});
		apb(1'b0, a, 32'h0, 1'b1);
	endtask
	task automatic cmd(logic [11:0] c);
		apb(1'b1, RTCSA_R_CMD, {20'h0, c}, 1'b0);
		rdat = 32'h1;
		while (rdat[RTCSA_ST_BUSY] === 1'b1)
			apb(1'b0, RTCSA_R_STATUS, 32'h0, 1'b0);
	endtask
	task automatic wr(inout logic [7:0] a, input int n, input logic stp);
		logic [7:0] d;
		logic       last;
		cmd(12'h1D0);
		cmd({4'h0, a});
		check("freeze", clock_freeze, a <= RTCSA_CLOCK_LAST);
		for (int i = 0; i < n; i++) begin
			d = rnd_byte();
			last = stp && i == n - 1;
			cmd({last ? 4'h2 : 4'h0, d});
			if (!fixed(a))
				mem[a] = d;
			a = (a == RTCSA_MAP_LAST) ? 8'h00 : a + 8'h01;
			check("pointer", word_pointer_value, a);
			check("freeze", clock_freeze, a <= 8'h07 && !last);
		end
	endtask
	task automatic rd(inout logic [7:0] a, input int n, input logic cur);
		if (!cur) begin
			cmd(12'h1D0);
			cmd({4'h0, a});
		end
		cmd(12'h1D1);
		check("freeze", clock_freeze, a <= RTCSA_CLOCK_LAST);
		for (int i = 0; i < n; i++) begin
			cmd(i == n - 1 ? 12'hE00 : 12'h400);
			expect_rd(RTCSA_R_RXDATA, {24'h0, model(a)}, 32'hFF);
			if (i < n - 1)
				a = (a == RTCSA_MAP_LAST) ? 8'h00 : a + 8'h01;
		end
		// the final nack must not advance the pointer
		check("pointer", word_pointer_value, a);
		check("freeze", clock_freeze, 1'b0);
	endtask
	task automatic wait_en();
		for (int i = 0; i < 6000 && access_enabled !== 1'b1; i++)
			@(posedge clk);
		check("enabled", access_enabled, 1'b1);
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	initial begin
		logic [7:0] p;
		reset = 1'b1;
		supply_ok = 1'b1;
		{psel, penable, pwrite, chk, paddr, pwdata} = '0;
		rnd_q = 32'h00128589;
		mismatches = 0;
		compares = 0;
		for (int i = 0; i < 160; i++)
			mem[i] = 8'h00;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("enabled", access_enabled, 1'b0);
		check("pointer", word_pointer_value, 8'h00);
		wait_en();
		expect_rd(8'h0C, RTCSA_ERR_WORD, 32'hFFFFFFFF);
		check("slverr", rerr, 1'b1);
		cmd(12'h3A2);
		expect_rd(RTCSA_R_STATUS, 32'h2, 32'h3);
		p = 8'h9E;
		wr(p, 4, 1'b1);
		rd(p, 3, 1'b1);
		p = 8'h9E;
		rd(p, 4, 1'b0);
		p = 8'h1D;
		wr(p, 2, 1'b1);
		p = 8'h1C;
		rd(p, 5, 1'b0);
		// transfer left open, then supply lost in mid-sequence
		p = 8'h30;
		wr(p, 1, 1'b0);
		supply_ok <= 1'b0;
		repeat (8) @(posedge clk);
		check("pointer", word_pointer_value, 8'h00);
		check("enabled", access_enabled, 1'b0);
		cmd(12'h2C3);
		expect_rd(RTCSA_R_STATUS, 32'h2, 32'h3);
		supply_ok <= 1'b1;
		repeat (200) @(posedge clk);
		check("enabled", access_enabled, 1'b0);
		wait_en();
		p = 8'h30;
		rd(p, 2, 1'b0);
		give_verdict();
	end
endmodule // rtc_serial_slave_access_tb
